// *** bench/breaker_model.sv ***
// Breaker model: raw contacts that follow command pulses
`timescale 1ns/1ns
module breaker_model (
    // Clock
    input  wire logic       clk,
    // Commands and bench controls
    input  wire logic       open_cmd,
    input  wire logic       close_cmd,
    input  wire logic       stray,
    input  wire logic [7:0] travel,
    input  wire logic       force_en,
    input  wire logic [1:0] force_val,
    // Raw contacts
    output logic            open_st,
    output logic            closed_st
);
    logic [1:0] pos_q = 2'h1;
    logic [1:0] tgt_q = 2'h1;
    int         cnt_q = 0;

    // Travel through intermediate, or move with no command at all
    always @(posedge clk) begin
        if (stray && cnt_q == 0) begin
            pos_q <= (pos_q == 2'h1) ? 2'h2 : 2'h1;
        end else if (cnt_q == 0 && (open_cmd || close_cmd)
                     && pos_q != (open_cmd ? 2'h1 : 2'h2)) begin
            tgt_q <= open_cmd ? 2'h1 : 2'h2;
            cnt_q <= int'(travel);
            pos_q <= 2'h0;
        end else if (cnt_q == 1) begin
            pos_q <= tgt_q;
            cnt_q <= 0;
        end else if (cnt_q > 1) begin
            cnt_q <= cnt_q - 1;
        end
    end

    // Closed contact on bit 1, open contact on bit 0
    assign {closed_st, open_st} = force_en ? force_val : pos_q;
endmodule : breaker_model

// *** bench/test_breaker_command_supervisor.sv ***
// Self-checking bench of the breaker command supervisor
`timescale 1ns/1ns
module test_breaker_command_supervisor;
    logic        CLK = 1'b0, RESET = 1'b1, WR = 1'b0, RD = 1'b0;
    logic [7:0]  ADDR = 8'h00;
    logic [31:0] WDATA = 32'h0000_0000, RDATA;
    logic        LOCAL_REQ = 1'b0, LOCAL_CMD = 1'b0, REMOTE_REQ = 1'b0, REMOTE_CMD = 1'b0;
    logic        LOCAL_PERMIT = 1'b1, REMOTE_PERMIT = 1'b1, SYNC_PERMIT = 1'b1;
    logic        OPEN_INTERLOCK_ENABLE = 1'b1, CLOSE_INTERLOCK_ENABLE = 1'b1;
    logic        OPERATION_BLOCK = 1'b0, EXTERNAL_SWITCH_FLAG = 1'b0;
    logic        BREAKER_OPEN_STATUS, BREAKER_CLOSED_STATUS, OPERATION_PULSE;
    logic        OPEN_COMMAND_PULSE, CLOSE_COMMAND_PULSE, SYNCHRO_SWITCH_START;
    logic        UNINTENDED_OPERATION_FLAG, OPENED, CLOSED, STATE_EVENT;
    logic [1:0]  BREAKER_STATE_CODE, force_val = 2'h0;
    logic        stray = 1'b0, force_en = 1'b0;
    logic [7:0]  travel = 8'h05;
    logic [2:0]  prev = 3'h0;
    logic [31:0] seed = 32'h0000_B1D4;
    int          failures = 0, num_checks = 0, n_open = 0, n_close = 0, n_ss = 0, n_ev = 0;
    int          cmd_len = 0, cmd_run = 0, op_len = 0, op_run = 0;
    int          exp_open = 0, exp_close = 0, exp_ops = 0;

    breaker_command_supervisor #(.MS_CYCLES(4)) dut (
        .CLK(CLK), .RESET(RESET), .ADDR(ADDR), .WDATA(WDATA), .WR(WR), .RD(RD),
        .RDATA(RDATA), .LOCAL_REQ(LOCAL_REQ), .LOCAL_CMD(LOCAL_CMD),
        .REMOTE_REQ(REMOTE_REQ), .REMOTE_CMD(REMOTE_CMD), .LOCAL_PERMIT(LOCAL_PERMIT),
        .REMOTE_PERMIT(REMOTE_PERMIT), .SYNC_PERMIT(SYNC_PERMIT),
        .OPEN_INTERLOCK_ENABLE(OPEN_INTERLOCK_ENABLE),
        .CLOSE_INTERLOCK_ENABLE(CLOSE_INTERLOCK_ENABLE), .OPERATION_BLOCK(OPERATION_BLOCK),
        .BREAKER_OPEN_STATUS(BREAKER_OPEN_STATUS),
        .BREAKER_CLOSED_STATUS(BREAKER_CLOSED_STATUS),
        .EXTERNAL_SWITCH_FLAG(EXTERNAL_SWITCH_FLAG), .OPEN_COMMAND_PULSE(OPEN_COMMAND_PULSE),
        .CLOSE_COMMAND_PULSE(CLOSE_COMMAND_PULSE), .SYNCHRO_SWITCH_START(SYNCHRO_SWITCH_START),
        .OPERATION_PULSE(OPERATION_PULSE), .UNINTENDED_OPERATION_FLAG(UNINTENDED_OPERATION_FLAG),
        .OPENED(OPENED), .CLOSED(CLOSED), .BREAKER_STATE_CODE(BREAKER_STATE_CODE),
        .STATE_EVENT(STATE_EVENT));

    breaker_model model (
        .clk(CLK), .open_cmd(OPEN_COMMAND_PULSE), .close_cmd(CLOSE_COMMAND_PULSE),
        .stray(stray), .travel(travel), .force_en(force_en), .force_val(force_val),
        .open_st(BREAKER_OPEN_STATUS), .closed_st(BREAKER_CLOSED_STATUS));

    // Clock of 4 ns
    initial begin
        forever #2 CLK = ~CLK;
    end

    // Rising edges and pulse lengths seen at the outputs
    always @(posedge CLK) begin
        n_open += int'(OPEN_COMMAND_PULSE === 1'b1 && !prev[0]);
        n_close += int'(CLOSE_COMMAND_PULSE === 1'b1 && !prev[1]);
        n_ss += int'(SYNCHRO_SWITCH_START === 1'b1 && !prev[2]);
        n_ev += int'(STATE_EVENT === 1'b1);
        prev = {SYNCHRO_SWITCH_START, CLOSE_COMMAND_PULSE, OPEN_COMMAND_PULSE};
        cmd_len = (cmd_run != 0 && prev[1:0] == 2'h0) ? cmd_run : cmd_len;
        cmd_run = (prev[1:0] != 2'h0) ? cmd_run + 1 : 0;
        op_len = (op_run != 0 && OPERATION_PULSE !== 1'b1) ? op_run : op_len;
        op_run = (OPERATION_PULSE === 1'b1) ? op_run + 1 : 0;
    end

    // Hang guard
    initial begin
        repeat (100000) @(posedge CLK);
        failures++;
        complete_run();
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic sel(input int k);
        case (k)
            0: return OPEN_COMMAND_PULSE;
            1: return CLOSE_COMMAND_PULSE;
            2: return OPERATION_PULSE;
            default: return SYNCHRO_SWITCH_START;
        endcase
    endfunction : sel

    task automatic complete_run();
        if (failures == 0 && num_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : complete_run

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : check

    task automatic cyc(input int n);
        repeat (n) @(posedge CLK);
        #1;
    endtask : cyc

    task automatic wait_lvl(input int k, input logic lvl, input int lim);
        for (int t = 0; t < lim && sel(k) !== lvl; t++) begin
            cyc(1);
        end
        if (sel(k) !== lvl) begin
            failures++;
            complete_run();
        end
    endtask : wait_lvl

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge CLK);
        ADDR <= a;
        WDATA <= d;
        WR <= 1'b1;
        @(posedge CLK);
        WR <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] v);
        @(posedge CLK);
        ADDR <= a;
        RD <= 1'b1;
        @(posedge CLK);
        RD <= 1'b0;
        #1;
        v = RDATA;
    endtask : rd

    task automatic req(input logic rem, input logic cmd);
        @(posedge CLK);
        {REMOTE_REQ, LOCAL_REQ} <= rem ? 2'h2 : 2'h1;
        {REMOTE_CMD, LOCAL_CMD} <= {cmd, cmd};
        @(posedge CLK);
        {REMOTE_REQ, LOCAL_REQ} <= 2'h0;
    endtask : req

    // Operation pulse, counter and filtered position after a move
    task automatic finish_op(input logic [1:0] pos, input logic unint);
        logic [31:0] v;
        wait_lvl(2, 1'b1, 300);
        wait_lvl(2, 1'b0, 700);
        exp_ops++;
        rd(8'h18, v);
        check(v, exp_ops);
        check({31'h0, op_len >= 596 && op_len <= 604}, 32'h1);
        check({30'h0, BREAKER_STATE_CODE}, {30'h0, pos});
        check({30'h0, CLOSED, OPENED}, {30'h0, pos});
        check({31'h0, UNINTENDED_OPERATION_FLAG}, {31'h0, unint});
    endtask : finish_op

    task automatic do_op(input logic rem, input logic cmd, input logic late);
        @(posedge CLK);
        travel <= 8'(5 + rnd() % 40);
        SYNC_PERMIT <= !late;
        req(rem, cmd);
        if (late) begin
            cyc(10);
            check(n_close, exp_close);
            @(posedge CLK);
            SYNC_PERMIT <= 1'b1;
        end
        wait_lvl(int'(cmd), 1'b1, 20);
        cyc(3);
        req(!rem, !cmd);
        wait_lvl(int'(cmd), 1'b0, 100);
        cyc(1);
        exp_open += int'(!cmd);
        exp_close += int'(cmd);
        check(n_open, exp_open);
        check(n_close, exp_close);
        check({31'h0, cmd_len >= 36 && cmd_len <= 44}, 32'h1);
        finish_op({cmd, !cmd}, 1'b0);
    endtask : do_op

    task automatic kick(input logic ext);
        @(posedge CLK);
        stray <= 1'b1;
        EXTERNAL_SWITCH_FLAG <= ext;
        @(posedge CLK);
        stray <= 1'b0;
        finish_op(ext ? 2'h1 : 2'h2, !ext);
        @(posedge CLK);
        EXTERNAL_SWITCH_FLAG <= 1'b0;
    endtask : kick

    // Main sequence
    initial begin
        logic [31:0] v;
        logic [7:0]  ra [5];
        logic [31:0] rv [5];
        ra = '{8'h04, 8'h08, 8'h0C, 8'h10, 8'h18};
        rv = '{32'h0000_012C, 32'h0000_0064, 32'h0000_03E8, 32'h0000_0000, 32'h0000_0000};
        repeat (16) @(posedge CLK);
        RESET <= 1'b0;
        cyc(4);
        for (int i = 0; i < 5; i++) begin
            rd(ra[i], v);
            check(v, rv[i]);
        end
        wr(8'h04, 32'h0000_000A);
        wr(8'h08, 32'h0000_0005);
        wr(8'h0C, 32'h0000_0005);
        wr(8'h1C, rnd());
        rd(8'h1C, v);
        check(v, 32'h0000_0000);
        check({30'h0, BREAKER_STATE_CODE}, 32'h0000_0001);
        // Requests refused by a missing permit, interlock or by the block
        for (int k = 0; k < 5; k++) begin
            @(posedge CLK);
            {LOCAL_PERMIT, REMOTE_PERMIT} <= {k != 0, k != 1};
            {OPEN_INTERLOCK_ENABLE, CLOSE_INTERLOCK_ENABLE} <= {k != 2, k != 3};
            OPERATION_BLOCK <= (k == 4);
            req(k == 1, k != 2);
            cyc(8);
            check(n_open + n_close, 0);
        end
        @(posedge CLK);
        {LOCAL_PERMIT, REMOTE_PERMIT, OPEN_INTERLOCK_ENABLE, CLOSE_INTERLOCK_ENABLE} <= 4'hF;
        OPERATION_BLOCK <= 1'b0;
        do_op(1'b0, 1'b1, 1'b1);
        do_op(1'b1, 1'b0, 1'b0);
        do_op(1'b1, 1'b1, 1'b0);
        do_op(1'b0, 1'b0, 1'b0);
        // Close never synchronised, without and then with synchro-switching
        for (int s = 0; s < 2; s++) begin
            wr(8'h10, 32'(s * 5));
            @(posedge CLK);
            SYNC_PERMIT <= 1'b0;
            req(1'b0, 1'b1);
            cyc(60);
            check(n_ss, s);
            check(n_close, exp_close);
        end
        @(posedge CLK);
        SYNC_PERMIT <= 1'b1;
        kick(1'b0);
        kick(1'b1);
        // Intermediate after its wait, bad at once, one event per change
        v = 32'(n_ev);
        @(posedge CLK);
        force_en <= 1'b1;
        cyc(6);
        check({30'h0, BREAKER_STATE_CODE}, 32'h0000_0001);
        cyc(30);
        check({30'h0, BREAKER_STATE_CODE}, 32'h0000_0000);
        @(posedge CLK);
        force_val <= 2'h3;
        cyc(3);
        check({30'h0, BREAKER_STATE_CODE}, 32'h0000_0003);
        @(posedge CLK);
        force_en <= 1'b0;
        cyc(4);
        check(32'(n_ev) - v, 32'h0000_0003);
        // Status word: idle, open, filtered opened, no pulse, no flag
        rd(8'h14, v);
        check(v, 32'h0000_008A);
        wr(8'h00, 32'h0000_0001);
        rd(8'h18, v);
        check(v, 32'h0000_0000);
        complete_run();
    end
endmodule : test_breaker_command_supervisor

// *** core/breaker_command_supervisor.sv ***
// Breaker command supervisor: gating, command pulses, status filter, counters
//
// Implementation choices: the placing of the registers and strobed register access.
`timescale 1ns/1ns
`include "cb_supervisor_defines.svh"

module breaker_command_supervisor #(
    parameter int MS_CYCLES = `CB_MS_CYCLES
) (
    // Clock and reset
    input  wire logic        CLK,
    input  wire logic        RESET,
    // Register port
    input  wire logic [7:0]  ADDR,
    input  wire logic [31:0] WDATA,
    input  wire logic        WR,
    input  wire logic        RD,
    output logic      [31:0] RDATA,
    // Operator requests, command value 0 open 1 close
    input  wire logic        LOCAL_REQ,
    input  wire logic        LOCAL_CMD,
    input  wire logic        REMOTE_REQ,
    input  wire logic        REMOTE_CMD,
    // Permits and interlocks
    input  wire logic        LOCAL_PERMIT,
    input  wire logic        REMOTE_PERMIT,
    input  wire logic        SYNC_PERMIT,
    input  wire logic        OPEN_INTERLOCK_ENABLE,
    input  wire logic        CLOSE_INTERLOCK_ENABLE,
    input  wire logic        OPERATION_BLOCK,
    // Breaker side
    input  wire logic        BREAKER_OPEN_STATUS,
    input  wire logic        BREAKER_CLOSED_STATUS,
    input  wire logic        EXTERNAL_SWITCH_FLAG,
    output logic             OPEN_COMMAND_PULSE,
    output logic             CLOSE_COMMAND_PULSE,
    output logic             SYNCHRO_SWITCH_START,
    // Indications
    output logic             OPERATION_PULSE,
    output logic             UNINTENDED_OPERATION_FLAG,
    output logic             OPENED,
    output logic             CLOSED,
    output logic      [1:0]  BREAKER_STATE_CODE,
    output logic             STATE_EVENT
);

    cb_supervisor_pkg::seq_state_t state_q;
    logic [31:0] div_q;
    logic        tick_q;
    logic [15:0] seq_ms_q;
    logic [15:0] int_ms_q;
    logic [15:0] oper_ms_q;
    logic [15:0] pulse_ms_q;
    logic [15:0] interm_ms_q;
    logic [15:0] synchk_ms_q;
    logic [15:0] synsw_ms_q;
    logic [1:0]  last_pos_q;
    logic [31:0] op_count_q;
    logic        cmd_seen_q;
    logic        ext_seen_q;
    logic        cmd_prev_q;
    logic [1:0]  raw_code;
    logic [1:0]  code_d;
    logic        loc_ok;
    logic        rem_ok;
    logic        req_ok;
    logic        req_close;
    logic        op_event;
    logic        clr_req;

    // Writes at a given offset
    function automatic logic wr_hit(input logic [7:0] off);
        return WR && (ADDR == off);
    endfunction : wr_hit

    // Millisecond enable from the clock divider
    always_ff @(posedge CLK) begin
        if (RESET || div_q == 32'(MS_CYCLES - 1)) begin
            div_q <= 32'h0000_0000;
        end else begin
            div_q <= div_q + 32'h0000_0001;
        end
        tick_q <= !RESET && (div_q == 32'(MS_CYCLES - 1));
    end

    // Request gating by source permit, local first
    assign loc_ok    = LOCAL_REQ && LOCAL_PERMIT;
    assign rem_ok    = REMOTE_REQ && REMOTE_PERMIT;
    assign req_ok    = loc_ok || rem_ok;
    assign req_close = loc_ok ? LOCAL_CMD : REMOTE_CMD;
    assign raw_code  = {BREAKER_CLOSED_STATUS, BREAKER_OPEN_STATUS};
    assign clr_req   = WR && (ADDR == `CB_REG_CTRL) && WDATA[`CB_CTRL_CLR_BIT];

    // Command sequencer
    always_ff @(posedge CLK) begin
        if (RESET || OPERATION_BLOCK) begin
            state_q  <= cb_supervisor_pkg::ST_IDLE;
            seq_ms_q <= 16'h0000;
        end else begin
            seq_ms_q <= tick_q ? seq_ms_q + 16'h0001 : seq_ms_q;
            case (state_q)
                cb_supervisor_pkg::ST_IDLE: begin
                    seq_ms_q <= 16'h0000;
                    if (req_ok && !req_close && OPEN_INTERLOCK_ENABLE) begin
                        state_q <= cb_supervisor_pkg::ST_OPEN;
                    end else if (req_ok && req_close && CLOSE_INTERLOCK_ENABLE) begin
                        state_q <= SYNC_PERMIT ? cb_supervisor_pkg::ST_CLOSE
                                               : cb_supervisor_pkg::ST_SYNC;
                    end
                end
                cb_supervisor_pkg::ST_SYNC: begin
                    if (!CLOSE_INTERLOCK_ENABLE) begin
                        state_q <= cb_supervisor_pkg::ST_IDLE;
                    end else if (SYNC_PERMIT) begin
                        state_q  <= cb_supervisor_pkg::ST_CLOSE;
                        seq_ms_q <= 16'h0000;
                    end else if (seq_ms_q >= synchk_ms_q) begin
                        state_q  <= (synsw_ms_q == 16'h0000) ? cb_supervisor_pkg::ST_IDLE
                                                             : cb_supervisor_pkg::ST_SWAIT;
                        seq_ms_q <= 16'h0000;
                    end
                end
                cb_supervisor_pkg::ST_SWAIT: begin
                    if (!CLOSE_INTERLOCK_ENABLE || synsw_ms_q == 16'h0000
                        || seq_ms_q >= synsw_ms_q) begin
                        state_q <= cb_supervisor_pkg::ST_IDLE;
                    end else if (SYNC_PERMIT) begin
                        state_q  <= cb_supervisor_pkg::ST_CLOSE;
                        seq_ms_q <= 16'h0000;
                    end
                end
                cb_supervisor_pkg::ST_OPEN: begin
                    if (seq_ms_q >= pulse_ms_q || (seq_ms_q >= `CB_MIN_PULSE_MS
                        && raw_code == cb_supervisor_pkg::POS_OPEN)) begin
                        state_q <= cb_supervisor_pkg::ST_IDLE;
                    end
                end
                cb_supervisor_pkg::ST_CLOSE: begin
                    if (seq_ms_q >= pulse_ms_q || (seq_ms_q >= `CB_MIN_PULSE_MS
                        && raw_code == cb_supervisor_pkg::POS_CLOSED)) begin
                        state_q <= cb_supervisor_pkg::ST_IDLE;
                    end
                end
                default: begin
                    state_q <= cb_supervisor_pkg::ST_IDLE;
                end
            endcase
        end
    end

    // Command outputs are one-hot state bits, straight from the flop
    assign OPEN_COMMAND_PULSE   = state_q[3];
    assign CLOSE_COMMAND_PULSE  = state_q[4];
    assign SYNCHRO_SWITCH_START = state_q[2];

    // Intermediate filter timer, runs only while neither contact is made
    always_ff @(posedge CLK) begin
        if (RESET || raw_code != cb_supervisor_pkg::POS_INTERM) begin
            int_ms_q <= 16'h0000;
        end else if (tick_q && int_ms_q != 16'hFFFF) begin
            int_ms_q <= int_ms_q + 16'h0001;
        end
    end

    // Next reported code: valid and bad at once, intermediate after the wait
    always_comb begin
        code_d = BREAKER_STATE_CODE;
        if (raw_code != cb_supervisor_pkg::POS_INTERM) begin
            code_d = raw_code;
        end else if (int_ms_q >= interm_ms_q) begin
            code_d = cb_supervisor_pkg::POS_INTERM;
        end
    end

    // Operation is a move to a position other than the last one
    assign op_event = (code_d == cb_supervisor_pkg::POS_OPEN
                       || code_d == cb_supervisor_pkg::POS_CLOSED)
                      && last_pos_q != 2'h0 && code_d != last_pos_q;

    // Reported state, filtered outputs and change event
    always_ff @(posedge CLK) begin
        if (RESET) begin
            BREAKER_STATE_CODE <= cb_supervisor_pkg::POS_INTERM;
            OPENED             <= 1'b0;
            CLOSED             <= 1'b0;
            STATE_EVENT        <= 1'b0;
            last_pos_q         <= 2'h0;
        end else begin
            BREAKER_STATE_CODE <= code_d;
            OPENED             <= code_d == cb_supervisor_pkg::POS_OPEN;
            CLOSED             <= code_d == cb_supervisor_pkg::POS_CLOSED;
            STATE_EVENT        <= code_d != BREAKER_STATE_CODE;
            if (code_d == cb_supervisor_pkg::POS_OPEN
                || code_d == cb_supervisor_pkg::POS_CLOSED) begin
                last_pos_q <= code_d;
            end
        end
    end

    // Operation pulse of fixed length
    always_ff @(posedge CLK) begin
        if (RESET) begin
            OPERATION_PULSE <= 1'b0;
            oper_ms_q       <= 16'h0000;
        end else if (op_event) begin
            OPERATION_PULSE <= 1'b1;
            oper_ms_q       <= 16'h0000;
        end else if (OPERATION_PULSE && tick_q) begin
            oper_ms_q <= oper_ms_q + 16'h0001;
            if (oper_ms_q + 16'h0001 >= `CB_OPER_MS) begin
                OPERATION_PULSE <= 1'b0;
            end
        end
    end

    // Operation counter, a count in the clearing cycle survives as one
    always_ff @(posedge CLK) begin
        if (RESET) begin
            op_count_q <= 32'h0000_0000;
        end else if (op_event && !OPERATION_PULSE) begin
            op_count_q <= clr_req ? 32'h0000_0001 : op_count_q + 32'h0000_0001;
        end else if (clr_req) begin
            op_count_q <= 32'h0000_0000;
        end
    end

    // Command memory takes a pulse at its start, so a tail after a move is no command
    always_ff @(posedge CLK) begin
        cmd_prev_q <= !RESET && (OPEN_COMMAND_PULSE || CLOSE_COMMAND_PULSE);
        if (RESET) begin
            cmd_seen_q                <= 1'b0;
            ext_seen_q                <= 1'b0;
            UNINTENDED_OPERATION_FLAG <= 1'b0;
        end else if (op_event) begin
            UNINTENDED_OPERATION_FLAG <= !(cmd_seen_q || ext_seen_q
                                          || EXTERNAL_SWITCH_FLAG);
            cmd_seen_q <= 1'b0;
            ext_seen_q <= 1'b0;
        end else begin
            cmd_seen_q <= cmd_seen_q || (!cmd_prev_q
                          && (OPEN_COMMAND_PULSE || CLOSE_COMMAND_PULSE));
            ext_seen_q <= ext_seen_q || EXTERNAL_SWITCH_FLAG;
        end
    end
    // Setting registers
    always_ff @(posedge CLK) begin
        if (RESET) begin
            pulse_ms_q  <= `CB_PULSE_RST;
            interm_ms_q <= `CB_INTERM_RST;
            synchk_ms_q <= `CB_SYNCHK_RST;
            synsw_ms_q  <= `CB_SYNSW_RST;
        end else begin
            if (wr_hit(`CB_REG_PULSE))  pulse_ms_q  <= WDATA[15:0];
            if (wr_hit(`CB_REG_INTERM)) interm_ms_q <= WDATA[15:0];
            if (wr_hit(`CB_REG_SYNCHK)) synchk_ms_q <= WDATA[15:0];
            if (wr_hit(`CB_REG_SYNSW))  synsw_ms_q  <= WDATA[15:0];
        end
    end

    // Read data one cycle after the strobe, zero otherwise
    always_ff @(posedge CLK) begin
        if (RESET || !RD) begin
            RDATA <= 32'h0000_0000;
        end else begin
            case (ADDR)
                `CB_REG_PULSE:  RDATA <= {16'h0000, pulse_ms_q};
                `CB_REG_INTERM: RDATA <= {16'h0000, interm_ms_q};
                `CB_REG_SYNCHK: RDATA <= {16'h0000, synchk_ms_q};
                `CB_REG_SYNSW:  RDATA <= {16'h0000, synsw_ms_q};
                `CB_REG_STATUS: RDATA <= {20'h0_0000, state_q, UNINTENDED_OPERATION_FLAG,
                                          OPERATION_PULSE, CLOSED, OPENED,
                                          BREAKER_STATE_CODE, OPERATION_BLOCK};
                `CB_REG_COUNT:  RDATA <= op_count_q;
                default:        RDATA <= 32'h0000_0000;
            endcase
        end
    end

    // Checks
    sequence s_open_start;
        $rose(OPEN_COMMAND_PULSE);
    endsequence
    sequence s_close_start;
        $rose(CLOSE_COMMAND_PULSE);
    endsequence

    chk_open_gating: assert property (@(posedge CLK) disable iff (RESET)
        s_open_start |-> $past(OPEN_INTERLOCK_ENABLE && !OPERATION_BLOCK))
        else $error("open pulse without open interlock");
    chk_close_gating: assert property (@(posedge CLK) disable iff (RESET)
        s_close_start |-> $past(CLOSE_INTERLOCK_ENABLE && SYNC_PERMIT))
        else $error("close pulse without permit");
    chk_block_stops: assert property (@(posedge CLK) disable iff (RESET)
        OPERATION_BLOCK |=> !OPEN_COMMAND_PULSE && !CLOSE_COMMAND_PULSE)
        else $error("command while blocked");
    chk_local_permit: assert property (@(posedge CLK) disable iff (RESET)
        state_q == cb_supervisor_pkg::ST_IDLE && LOCAL_REQ && !LOCAL_PERMIT && !REMOTE_REQ
        |=> state_q == cb_supervisor_pkg::ST_IDLE)
        else $error("local request taken without permit");
    chk_synsw_zero: assert property (@(posedge CLK) disable iff (RESET)
        (synsw_ms_q == 16'h0000) [*2] |-> !SYNCHRO_SWITCH_START)
        else $error("synchro-switch started with zero wait");
    chk_oper_length: assert property (@(posedge CLK) disable iff (RESET)
        $rose(OPERATION_PULSE) |-> OPERATION_PULSE [*8])
        else $error("operation pulse too short");
    chk_count_step: assert property (@(posedge CLK) disable iff (RESET)
        $rose(OPERATION_PULSE) && !$past(clr_req)
        |-> op_count_q == $past(op_count_q) + 32'h0000_0001)
        else $error("counter did not step");
    chk_count_clear: assert property (@(posedge CLK) disable iff (RESET)
        clr_req && !op_event |=> op_count_q == 32'h0000_0000)
        else $error("counter not cleared");
    chk_code_map: assert property (@(posedge CLK) disable iff (RESET)
        BREAKER_STATE_CODE == cb_supervisor_pkg::POS_OPEN |-> OPENED && !CLOSED)
        else $error("opened output disagrees with code");
    chk_state_event: assert property (@(posedge CLK) disable iff (RESET)
        BREAKER_STATE_CODE != $past(BREAKER_STATE_CODE) |-> STATE_EVENT)
        else $error("state change without event");

endmodule : breaker_command_supervisor

// *** core/cb_supervisor_defines.svh ***
// Register offsets, reset values and timing constants of the breaker supervisor
`ifndef CB_SUPERVISOR_DEFINES_SVH
`define CB_SUPERVISOR_DEFINES_SVH

// Clock and millisecond time base
`define CB_CLK_PERIOD_NS 4
`define CB_MS_NS         1000000
`define CB_MS_CYCLES     (`CB_MS_NS / `CB_CLK_PERIOD_NS)

// Fixed durations in ms
`define CB_OPER_MS       16'h0096
`define CB_MIN_PULSE_MS  16'h0064

// Register byte offsets
`define CB_REG_CTRL      8'h00
`define CB_REG_PULSE     8'h04
`define CB_REG_INTERM    8'h08
`define CB_REG_SYNCHK    8'h0C
`define CB_REG_SYNSW     8'h10
`define CB_REG_STATUS    8'h14
`define CB_REG_COUNT     8'h18

// Control fields
`define CB_CTRL_CLR_BIT  0

// Setting reset values in ms
`define CB_PULSE_RST     16'h012C
`define CB_INTERM_RST    16'h0064
`define CB_SYNCHK_RST    16'h03E8
`define CB_SYNSW_RST     16'h0000

`endif

// *** core/cb_supervisor_pkg.sv ***
// Types of the breaker command supervisor
package cb_supervisor_pkg;

    // Command sequencer states
    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_SYNC  = 5'h02,
        ST_SWAIT = 5'h04,
        ST_OPEN  = 5'h08,
        ST_CLOSE = 5'h10
    } seq_state_t;

    // Reported breaker position
    typedef enum logic [1:0] {
        POS_INTERM = 2'h0,
        POS_OPEN   = 2'h1,
        POS_CLOSED = 2'h2,
        POS_BAD    = 2'h3
    } pos_code_t;

endpackage : cb_supervisor_pkg
